// ===== pkg/ivp_pkg.sv
package ivp_pkg;

   // -----------------------------------------------------------------
   // Widths and table geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W      = 13;
   localparam int NUM_SOURCES = 25;
   localparam int IDX_W       = 5;

   // -----------------------------------------------------------------
   // Fixed addresses and offsets
   // -----------------------------------------------------------------
   localparam logic [12:0] APP_RESET_ADDR  = 13'h0000;
   localparam logic [12:0] TABLE_FIRST_OFS = 13'h0001;
   localparam logic [12:0] BOOT_RESET_DEF  = 13'h0C00;
   localparam logic        FUSE_UNPROG     = 1'h1;

   // -----------------------------------------------------------------
   // Vector offsets, one word per source
   // -----------------------------------------------------------------
   localparam logic [12:0] OFS_EXT_REQ_ZERO   = 13'h0001;
   localparam logic [12:0] OFS_EXT_REQ_ONE    = 13'h0002;
   localparam logic [12:0] OFS_PIN_GROUP_ZERO = 13'h0003;
   localparam logic [12:0] OFS_PIN_GROUP_ONE  = 13'h0004;
   localparam logic [12:0] OFS_PIN_GROUP_TWO  = 13'h0005;
   localparam logic [12:0] OFS_WATCHDOG       = 13'h0006;
   localparam logic [12:0] OFS_T2_MATCH_A     = 13'h0007;
   localparam logic [12:0] OFS_T2_MATCH_B     = 13'h0008;
   localparam logic [12:0] OFS_T2_OVERFLOW    = 13'h0009;
   localparam logic [12:0] OFS_T1_CAPTURE     = 13'h000A;
   localparam logic [12:0] OFS_T1_MATCH_A     = 13'h000B;
   localparam logic [12:0] OFS_T1_MATCH_B     = 13'h000C;
   localparam logic [12:0] OFS_T1_OVERFLOW    = 13'h000D;
   localparam logic [12:0] OFS_T0_MATCH_A     = 13'h000E;
   localparam logic [12:0] OFS_T0_MATCH_B     = 13'h000F;
   localparam logic [12:0] OFS_T0_OVERFLOW    = 13'h0010;
   localparam logic [12:0] OFS_SERIAL_DONE    = 13'h0011;
   localparam logic [12:0] OFS_RX_DONE        = 13'h0012;
   localparam logic [12:0] OFS_TX_EMPTY       = 13'h0013;
   localparam logic [12:0] OFS_TX_DONE        = 13'h0014;
   localparam logic [12:0] OFS_ADC_DONE       = 13'h0015;
   localparam logic [12:0] OFS_EEPROM_READY   = 13'h0016;
   localparam logic [12:0] OFS_COMPARATOR     = 13'h0017;
   localparam logic [12:0] OFS_TWO_WIRE       = 13'h0018;
   localparam logic [12:0] OFS_STORE_READY    = 13'h0019;

   // -----------------------------------------------------------------
   // Interrupt source index (0 = external request zero)
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      SRC_EXTERNAL_REQUEST_ZERO,
      SRC_EXTERNAL_REQUEST_ONE,
      SRC_PIN_CHANGE_GROUP_ZERO,
      SRC_PIN_CHANGE_GROUP_ONE,
      SRC_PIN_CHANGE_GROUP_TWO,
      SRC_WATCHDOG_TIMEOUT,
      SRC_T2_COMPARE_MATCH_A,
      SRC_T2_COMPARE_MATCH_B,
      SRC_T2_COUNTER_OVERFLOW,
      SRC_T1_INPUT_CAPTURE_EVENT,
      SRC_T1_COMPARE_MATCH_A,
      SRC_T1_COMPARE_MATCH_B,
      SRC_T1_COUNTER_OVERFLOW,
      SRC_T0_COMPARE_MATCH_A,
      SRC_T0_COMPARE_MATCH_B,
      SRC_T0_COUNTER_OVERFLOW,
      SRC_SERIAL_TRANSFER_COMPLETE,
      SRC_USART_RECEIVE_COMPLETE,
      SRC_TRANSMIT_BUFFER_EMPTY,
      SRC_USART_TRANSMIT_COMPLETE,
      SRC_ADC_CONVERSION_COMPLETE,
      SRC_EEPROM_READY_EVENT,
      SRC_ANALOG_COMPARATOR,
      SRC_TWO_WIRE_INTERFACE,
      SRC_PROGRAM_STORE_READY
   } ivp_source_t;

   // -----------------------------------------------------------------
   // Request from the core and answer to it
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        reset_fetch;
      logic        irq_fetch;
      ivp_source_t source;
   } ivp_req_t;

   typedef struct packed {
      logic        valid;
      logic [12:0] addr;
   } ivp_vec_t;

endpackage

// ===== verilog/ivp_vector_gen.sv
// How it works
// - Unprogrammed boot-reset fuse: every reset kind vectors to word 0x000.
// - External request zero is offset 0x001, external request one 0x002.
// - Pin-change groups zero, one and two map to offsets 0x003, 0x004, 0x005.
// - Watchdog 0x006; second 8-bit timer match A, B, overflow 0x007-0x009.
// - The 16-bit timer capture, compare A, compare B, overflow are 0x00A-0x00D.
// - The first 8-bit timer compare A, compare B, overflow are 0x00E-0x010.
// - Serial done 0x011; USART receive, buffer empty, sent 0x012-0x014.
// - ADC 0x015, EEPROM 0x016, comparator 0x017, two-wire 0x018, store 0x019.
// - A programmed boot-reset fuse sends every reset to the boot reset address.
// - Fuse value 1 means unprogrammed and 0 means programmed.
// - With the vector-select bit set each interrupt vector is its offset plus boot start.
// - Table start is set apart from reset: 0x001, or boot address plus 0x001.
module ivp_vector_gen #(
   parameter logic [12:0] BOOT_RESET_ADDR = ivp_pkg::BOOT_RESET_DEF
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire ivp_pkg::ivp_req_t i_req,
   input  wire logic              i_boot_reset_select_fuse,
   input  wire logic              i_vector_table_in_boot_bit,
   output ivp_pkg::ivp_vec_t      o_vec
);

   // ----------------------------------------------------------------
   // Fuse pin synchroniser
   // ----------------------------------------------------------------
   // Fuse is a pin level: three stages, take it once stages 2 and 3 agree
   logic [2:0] fuse_sync;
   logic       fuse_level;
   wire  logic fuse_agree = (fuse_sync[1] == fuse_sync[2]);
   wire  logic next_fuse_level = fuse_agree ? fuse_sync[2] : fuse_level;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         fuse_sync  <= {3{ivp_pkg::FUSE_UNPROG}};
         fuse_level <= ivp_pkg::FUSE_UNPROG;
      end else begin
         fuse_sync  <= {fuse_sync[1:0], i_boot_reset_select_fuse};
         fuse_level <= next_fuse_level;
      end
   end

   // ----------------------------------------------------------------
   // Address formation
   // ----------------------------------------------------------------
   // Spelled out per source, so a reordered enum cannot shift the table
   logic [12:0] src_ofs;

   always_comb begin
      unique case (i_req.source)
         ivp_pkg::SRC_EXTERNAL_REQUEST_ZERO:
            src_ofs = ivp_pkg::OFS_EXT_REQ_ZERO;
         ivp_pkg::SRC_EXTERNAL_REQUEST_ONE:
            src_ofs = ivp_pkg::OFS_EXT_REQ_ONE;
         ivp_pkg::SRC_PIN_CHANGE_GROUP_ZERO:
            src_ofs = ivp_pkg::OFS_PIN_GROUP_ZERO;
         ivp_pkg::SRC_PIN_CHANGE_GROUP_ONE:
            src_ofs = ivp_pkg::OFS_PIN_GROUP_ONE;
         ivp_pkg::SRC_PIN_CHANGE_GROUP_TWO:
            src_ofs = ivp_pkg::OFS_PIN_GROUP_TWO;
         ivp_pkg::SRC_WATCHDOG_TIMEOUT:
            src_ofs = ivp_pkg::OFS_WATCHDOG;
         ivp_pkg::SRC_T2_COMPARE_MATCH_A:
            src_ofs = ivp_pkg::OFS_T2_MATCH_A;
         ivp_pkg::SRC_T2_COMPARE_MATCH_B:
            src_ofs = ivp_pkg::OFS_T2_MATCH_B;
         ivp_pkg::SRC_T2_COUNTER_OVERFLOW:
            src_ofs = ivp_pkg::OFS_T2_OVERFLOW;
         ivp_pkg::SRC_T1_INPUT_CAPTURE_EVENT:
            src_ofs = ivp_pkg::OFS_T1_CAPTURE;
         ivp_pkg::SRC_T1_COMPARE_MATCH_A:
            src_ofs = ivp_pkg::OFS_T1_MATCH_A;
         ivp_pkg::SRC_T1_COMPARE_MATCH_B:
            src_ofs = ivp_pkg::OFS_T1_MATCH_B;
         ivp_pkg::SRC_T1_COUNTER_OVERFLOW:
            src_ofs = ivp_pkg::OFS_T1_OVERFLOW;
         ivp_pkg::SRC_T0_COMPARE_MATCH_A:
            src_ofs = ivp_pkg::OFS_T0_MATCH_A;
         ivp_pkg::SRC_T0_COMPARE_MATCH_B:
            src_ofs = ivp_pkg::OFS_T0_MATCH_B;
         ivp_pkg::SRC_T0_COUNTER_OVERFLOW:
            src_ofs = ivp_pkg::OFS_T0_OVERFLOW;
         ivp_pkg::SRC_SERIAL_TRANSFER_COMPLETE:
            src_ofs = ivp_pkg::OFS_SERIAL_DONE;
         ivp_pkg::SRC_USART_RECEIVE_COMPLETE:
            src_ofs = ivp_pkg::OFS_RX_DONE;
         ivp_pkg::SRC_TRANSMIT_BUFFER_EMPTY:
            src_ofs = ivp_pkg::OFS_TX_EMPTY;
         ivp_pkg::SRC_USART_TRANSMIT_COMPLETE:
            src_ofs = ivp_pkg::OFS_TX_DONE;
         ivp_pkg::SRC_ADC_CONVERSION_COMPLETE:
            src_ofs = ivp_pkg::OFS_ADC_DONE;
         ivp_pkg::SRC_EEPROM_READY_EVENT:
            src_ofs = ivp_pkg::OFS_EEPROM_READY;
         ivp_pkg::SRC_ANALOG_COMPARATOR:
            src_ofs = ivp_pkg::OFS_COMPARATOR;
         ivp_pkg::SRC_TWO_WIRE_INTERFACE:
            src_ofs = ivp_pkg::OFS_TWO_WIRE;
         ivp_pkg::SRC_PROGRAM_STORE_READY:
            src_ofs = ivp_pkg::OFS_STORE_READY;
         // Codes past the last source: land on the first table word
         default:
            src_ofs = ivp_pkg::TABLE_FIRST_OFS;
      endcase
   end

   // Fuse 1 means unprogrammed
   wire logic boot_reset = (fuse_level != ivp_pkg::FUSE_UNPROG);

   wire logic [12:0] reset_addr = boot_reset ? BOOT_RESET_ADDR
                                             : ivp_pkg::APP_RESET_ADDR;

   // Select bit comes from core logic on this clock, so no synchroniser
   wire logic [12:0] table_base = i_vector_table_in_boot_bit
                                  ? BOOT_RESET_ADDR
                                  : ivp_pkg::APP_RESET_ADDR;

   wire logic [12:0] irq_addr = table_base + src_ofs;

   // Reset fetch wins if both requested at once
   wire logic [12:0] next_addr = i_req.reset_fetch ? reset_addr
                                                   : irq_addr;
   wire logic next_valid = i_req.reset_fetch | i_req.irq_fetch;

   // ----------------------------------------------------------------
   // Output register
   // ----------------------------------------------------------------
   // Address holds after valid drops, so the core may latch it late
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_vec.valid <= 1'h0;
         o_vec.addr  <= ivp_pkg::APP_RESET_ADDR;
      end else begin
         o_vec.valid <= next_valid;
         if (next_valid) begin
            o_vec.addr <= next_addr;
         end
      end
   end

endmodule

// ===== tb/ivp_vector_gen_asserts.sv
module ivp_vector_gen_asserts #(
   parameter logic [12:0] BOOT_RESET_ADDR = 13'h0C00
) (
   input wire logic              i_core_clk,
   input wire logic              i_rst,
   input wire ivp_pkg::ivp_req_t i_req,
   input wire logic              i_boot_reset_select_fuse,
   input wire logic              i_vector_table_in_boot_bit,
   input wire ivp_pkg::ivp_vec_t o_vec
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   wire        rq = i_req.reset_fetch | i_req.irq_fetch;
   wire        iq = i_req.irq_fetch & ~i_req.reset_fetch;
   wire        vt = i_vector_table_in_boot_bit;
   wire [12:0] ofs = 13'(i_req.source) + 13'h0001;
   // Fuse crosses a synchroniser, so only a settled level counts
   sequence fuse_hi; i_boot_reset_select_fuse [*6]; endsequence
   sequence fuse_lo; !i_boot_reset_select_fuse [*6]; endsequence
   a_answer_next: assert property (rq |=> o_vec.valid)
      else $error("no answer");
   a_no_spurious: assert property (!rq |=> !o_vec.valid)
      else $error("extra answer");
   a_addr_hold: assert property (!rq |=> $stable(o_vec.addr))
      else $error("addr moved");
   a_app_reset: assert property (fuse_hi ##0 i_req.reset_fetch
      |=> o_vec.addr == 13'h0000) else $error("app reset");
   a_boot_reset: assert property (fuse_lo ##0 i_req.reset_fetch
      |=> o_vec.addr == BOOT_RESET_ADDR) else $error("boot reset");
   a_irq_app: assert property (iq && !vt |=> o_vec.addr == $past(ofs))
      else $error("app vector");
   a_irq_boot: assert property (iq && vt
      |=> o_vec.addr == BOOT_RESET_ADDR + $past(ofs)) else $error("boot vec");
   a_table_range: assert property (iq && !vt
      |=> o_vec.addr inside {[13'h0001:13'h0019]}) else $error("range");
endmodule
bind ivp_vector_gen ivp_vector_gen_asserts #(
   .BOOT_RESET_ADDR(BOOT_RESET_ADDR)) ivp_vector_gen_asserts_inst (.i_core_clk,
   .i_rst, .i_req, .i_boot_reset_select_fuse, .i_vector_table_in_boot_bit,
   .o_vec);

// ===== tb/ivp_core_model.sv
module ivp_core_model (
   output ivp_pkg::ivp_req_t o_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_req = '0;
   // Drives whatever request it is handed, with no check of enabled sources
   task automatic ask(input logic r, input logic i, input logic [4:0] s);
      o_req = '{r, i, ivp_pkg::ivp_source_t'(s)};
   endtask
endmodule

// ===== tb/ivp_vector_gen_test.sv
module ivp_vector_gen_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [12:0] BOOT = 13'h0A00;
   logic clk = 0, rst = 1, fuse = 1, vtb = 0;
   ivp_pkg::ivp_req_t req;
   ivp_pkg::ivp_vec_t vec;
   logic [12:0] q[$];
   int errors = 0, tests_run = 0, cyc = 0;
   always #12.5 clk = ~clk;
   ivp_core_model ivp_core_model_inst (.o_req(req));
   ivp_vector_gen #(.BOOT_RESET_ADDR(BOOT)) ivp_vector_gen_inst (
      .i_core_clk(clk), .i_rst(rst), .i_req(req), .o_vec(vec),
      .i_boot_reset_select_fuse(fuse), .i_vector_table_in_boot_bit(vtb));
   task automatic ask(logic r, logic i, logic [4:0] s, logic v);
      @(negedge clk);
      vtb = v;
      ivp_core_model_inst.ask(r, i, s);
      q.push_back(r ? (fuse ? 13'h0000 : BOOT)
                    : (v ? BOOT : 13'h0000) + 13'(s) + 13'h0001);
   endtask
   task automatic idle(int n);
      @(negedge clk);
      ivp_core_model_inst.ask(0, 0, 0);
      repeat (n) @(negedge clk);
   endtask
   task automatic end_of_test;
      $display("counts: %0d checks, %0d errors", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(negedge clk) if (vec.valid === 1'b1) begin
      tests_run++;
      if (q.size() == 0 || vec.addr !== q.pop_front()) begin
         errors++;
         $display("mismatch at %0t: vector address", $time);
      end
   end
   always @(posedge clk) if (++cyc == 2000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test;
   end
   initial begin
      void'($urandom(6040));
      repeat (8) @(negedge clk);
      rst = 0;
      idle(6);
      for (int s = 0; s < 25; s++) ask(0, 1, s, 0);
      idle(2);
      $display("table test done");
      repeat (40) ask(0, 1, $urandom % 25, $urandom % 2);
      idle(2);
      $display("random test done");
      ask(1, 1, 24, 1);
      fuse = 0;
      idle(6);
      ask(1, 0, 3, 0);
      ask(0, 1, 0, 0);
      ask(0, 1, 24, 1);
      idle(2);
      $display("reset test done");
      rst = 1;
      repeat (2) @(negedge clk);
      tests_run++;
      if (vec.valid !== 1'b0 || vec.addr !== 13'h0000) begin
         errors++;
         $display("mismatch at %0t: reset state", $time);
      end
      rst = 0;
      idle(6);
      ask(1, 0, 0, 0);
      idle(2);
      $display("mid reset test done");
      if (q.size() != 0) begin
         errors++;
         $display("mismatch at %0t: missing answers", $time);
      end
      end_of_test;
   end
endmodule
